// >>> sec_acc_pkg.sv
// Purpose: Constants and types for the secondary accumulator slice
// Assumes: One core clock, AXI4-Lite register access
// Notes:   Register byte offsets are word aligned
package sec_acc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ACC0_HIGH  = 8'h00;
  localparam logic [7:0] OFF_ACC0_LOW   = 8'h04;
  localparam logic [7:0] OFF_ACC1_HIGH  = 8'h08;
  localparam logic [7:0] OFF_ACC1_LOW   = 8'h0c;
  localparam logic [7:0] OFF_SHIFT_CNT  = 8'h10;
  localparam logic [7:0] OFF_STATUS0    = 8'h14;
  localparam logic [7:0] OFF_STATUS2    = 8'h18;
  localparam logic [7:0] OFF_ACC0_EXT   = 8'h1c;
  localparam logic [7:0] OFF_ACC1_EXT   = 8'h20;

  // ----------------------------------------------------------------
  // Status word zero and two fields
  // ----------------------------------------------------------------
  localparam int ST0_CLAMP_DIS = 0;
  localparam int ST0_EXT_CROSS = 1;
  localparam int ST0_SIGN_LOSS = 2;
  localparam int ST0_LIMIT     = 3;
  localparam int ST2_SHIFT_KIND = 0;

  // ----------------------------------------------------------------
  // Widths, saturation values, responses
  // ----------------------------------------------------------------
  localparam int ACC_W  = 36;
  localparam int HALF_W = 16;
  localparam logic [15:0] SAT_HIGH_POS = 16'h7fff;
  localparam logic [15:0] SAT_HIGH_NEG = 16'h8000;
  localparam logic [15:0] SAT_LOW_POS  = 16'hffff;
  localparam logic [15:0] SAT_LOW_NEG  = 16'h0000;
  localparam logic [35:0] CLAMP_POS    = 36'h07fffffff;
  localparam logic [35:0] CLAMP_NEG    = 36'hf80000000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // Datapath operations issued by instruction control
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_SWAP  = 3'b001,
    OP_SHIFT = 3'b011,
    OP_CLAMP = 3'b010,
    OP_EXP   = 3'b110
  } dp_op_t;

endpackage

// >>> sec_acc_slice.sv
// Purpose: Secondary accumulators, shift count and move saturation
// Assumes: Register bus is AXI4-Lite; ops arrive as one-cycle strobes
// Notes:   Extension nibbles are read only over the bus
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Two 36-bit accumulators, halves bus accessible
// - Exchange with primary accumulators in one cycle
// - Accumulators feed exponent unit and shifter
// - Flags update from field, ALU, shifter ops
// - Shifter result past bit 31 sets cross
// - Sign loss sets sign-loss and sticky limit
// - High-half writes sign-extend through 36 bits; low-half writes zero-fill
// - Writing one half clears the other
// - Full 36-bit load by shift or exchange
// - Extension reachable only by shift, exchange, clamp, high-half write sign extension or low-half write zero fill
// - Shift count register drives shift amount
// - Exponent result written to shift count
// - Shift count is also a data register
// - Overflowed moves and clamps give full scale
// - Move saturation leaves accumulator unchanged
// - Saturated values 7fff/ffff or 8000/0000
// - Saturation uses current accumulator contents
// - Saturation correct after exchange
// - Disable bit stops move saturation only
// - Actual limiting sets sticky limit flag
// - Right shift kind from status two bit
module sec_acc_slice
  import sec_acc_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output var  logic        o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output var  logic        o_wready,
  output var  logic [1:0]  o_bresp,
  output var  logic        o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output var  logic        o_arready,
  output var  logic [31:0] o_rdata,
  output var  logic [1:0]  o_rresp,
  output var  logic        o_rvalid,
  input  wire logic        i_rready,
  // Core datapath side
  input  wire logic [2:0]  i_op,
  input  wire logic        i_op_sel,
  input  wire logic        i_op_src,
  input  wire logic [35:0] i_primary_acc,
  input  wire logic [35:0] i_shift_src,
  input  wire logic        i_shift_use_count,
  input  wire logic [6:0]  i_shift_imm,
  input  wire logic        i_alu_flag_we,
  input  wire logic [3:0]  i_alu_flags,
  output var  logic [35:0] o_to_primary,
  output var  logic [35:0] o_operand,
  output var  logic [15:0] o_shift_count
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [35:0] acc_q [2];
  logic [15:0] shift_cnt_q;
  logic [3:0]  st0_q;
  logic        st2_kind_q;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic overflowed(input logic [35:0] a);
    overflowed = !((a[35:31] == 5'h00) || (a[35:31] == 5'h1f));
  endfunction

  // Saturated view of one half for the bus
  function automatic logic [15:0] move_value(input logic [35:0] a,
                                             input logic hi,
                                             input logic dis);
    if (!dis && overflowed(a)) begin
      if (a[35]) begin
        move_value = hi ? SAT_HIGH_NEG : SAT_LOW_NEG;
      end else begin
        move_value = hi ? SAT_HIGH_POS : SAT_LOW_POS;
      end
    end else begin
      move_value = hi ? a[31:16] : a[15:0];
    end
  endfunction

  function automatic logic [5:0] exponent(input logic [35:0] a);
    logic [5:0] n;
    n = 6'd0;
    for (int k = 35; k >= 0; k--) begin
      if (a[k] == a[35] && n == 6'(35 - k)) begin
        n = n + 6'd1;
      end
    end
    exponent = n - 6'd5;
  endfunction

  // ----------------------------------------------------------------
  // Barrel shifter
  // ----------------------------------------------------------------
  logic signed [6:0] sh_amt;
  logic [35:0]       sh_in;
  logic [71:0]       sh_ext;
  logic [71:0]       sh_wide;
  logic [35:0]       sh_res;
  logic              sh_cross;
  logic              sh_loss;
  logic [6:0]        sh_mag;

  always_comb begin
    sh_amt  = i_shift_use_count ? shift_cnt_q[6:0] : i_shift_imm;
    sh_in   = i_op_src ? acc_q[i_op_sel] : i_shift_src;
    sh_ext  = {{36{sh_in[35] & ~st2_kind_q}}, sh_in};
    sh_mag  = sh_amt[6] ? 7'(-sh_amt) : sh_amt;
    if (sh_amt[6]) begin
      sh_wide = sh_ext >> sh_mag;
    end else begin
      sh_wide = sh_ext << sh_mag;
    end
    sh_res   = sh_wide[35:0];
    sh_cross = (sh_res[35:31] != {5{sh_res[31]}});
    sh_loss  = !sh_amt[6] && (sh_wide[71:35] != {37{sh_res[35]}});
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_hit;

  assign wr_fire = aw_have_q && w_have_q && !o_bvalid;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Ready flags registered from the next holding state
  logic aw_have_d;
  logic w_have_d;
  logic bvalid_d;

  always_comb begin
    aw_have_d = (i_awvalid && o_awready) || (aw_have_q && !wr_fire);
    w_have_d  = (i_wvalid && o_wready) || (w_have_q && !wr_fire);
    bvalid_d  = wr_fire || (o_bvalid && !i_bready);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
    end else begin
      o_awready <= !aw_have_d && !bvalid_d;
      o_wready  <= !w_have_d && !bvalid_d;
    end
  end

  always_comb begin
    wr_hit = (aw_addr_q == OFF_ACC0_HIGH) || (aw_addr_q == OFF_ACC0_LOW) ||
             (aw_addr_q == OFF_ACC1_HIGH) || (aw_addr_q == OFF_ACC1_LOW) ||
             (aw_addr_q == OFF_SHIFT_CNT) || (aw_addr_q == OFF_STATUS0) ||
             (aw_addr_q == OFF_STATUS2);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Sixteen-bit write data, byte lanes honoured
  logic [15:0] wval;
  assign wval = {w_strb_q[1] ? w_data_q[15:8] : 8'h00,
                 w_strb_q[0] ? w_data_q[7:0]  : 8'h00};

  // ----------------------------------------------------------------
  // Accumulator update
  // ----------------------------------------------------------------
  logic [35:0] clamp_res;
  logic        clamp_hit;

  always_comb begin
    clamp_hit = overflowed(acc_q[i_op_sel]);
    clamp_res = clamp_hit ? (acc_q[i_op_sel][35] ? CLAMP_NEG : CLAMP_POS)
                          : acc_q[i_op_sel];
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      acc_q[0] <= 36'h0;
      acc_q[1] <= 36'h0;
    end else begin
      case (dp_op_t'(i_op))
        OP_SWAP: begin
          acc_q[i_op_sel] <= i_primary_acc;
        end
        OP_SHIFT: begin
          acc_q[i_op_sel] <= sh_res;
        end
        OP_CLAMP: begin
          acc_q[i_op_sel] <= clamp_res;
        end
        default: begin
          if (wr_fire) begin
            if (aw_addr_q == OFF_ACC0_HIGH) begin
              acc_q[0] <= {{4{wval[15]}}, wval, 16'h0000};
            end else if (aw_addr_q == OFF_ACC0_LOW) begin
              acc_q[0] <= {20'h00000, wval};
            end else if (aw_addr_q == OFF_ACC1_HIGH) begin
              acc_q[1] <= {{4{wval[15]}}, wval, 16'h0000};
            end else if (aw_addr_q == OFF_ACC1_LOW) begin
              acc_q[1] <= {20'h00000, wval};
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift count register and status words
  // ----------------------------------------------------------------
  logic [5:0] exp_val;

  assign exp_val = exponent(acc_q[i_op_sel]);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      shift_cnt_q <= 16'h0000;
    end else if (dp_op_t'(i_op) == OP_EXP) begin
      shift_cnt_q <= {{10{exp_val[5]}}, exp_val};
    end else if (wr_fire && aw_addr_q == OFF_SHIFT_CNT) begin
      shift_cnt_q <= wval;
    end
  end

  // Move limiting event from a bus read of a half
  logic rd_limit;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st0_q      <= 4'h0;
      st2_kind_q <= 1'b0;
    end else begin
      if (wr_fire && aw_addr_q == OFF_STATUS2) begin
        st2_kind_q <= wval[ST2_SHIFT_KIND];
      end
      if (wr_fire && aw_addr_q == OFF_STATUS0) begin
        st0_q <= wval[3:0];
      end
      if (i_alu_flag_we) begin
        st0_q[ST0_EXT_CROSS] <= i_alu_flags[ST0_EXT_CROSS];
        st0_q[ST0_SIGN_LOSS] <= i_alu_flags[ST0_SIGN_LOSS];
        if (i_alu_flags[ST0_SIGN_LOSS]) begin
          st0_q[ST0_LIMIT] <= 1'b1;
        end
      end
      if (dp_op_t'(i_op) == OP_SHIFT) begin
        st0_q[ST0_EXT_CROSS] <= sh_cross;
        st0_q[ST0_SIGN_LOSS] <= sh_loss;
        if (sh_loss) begin
          st0_q[ST0_LIMIT] <= 1'b1;
        end
      end
      if ((dp_op_t'(i_op) == OP_CLAMP && clamp_hit) || rd_limit) begin
        st0_q[ST0_LIMIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [15:0] rd_val;
  logic        rd_ok;
  logic        rd_fire;

  assign rd_fire = i_arvalid && o_arready;

  always_comb begin
    rd_val   = 16'h0000;
    rd_ok    = 1'b1;
    rd_limit = 1'b0;
    if (i_araddr == OFF_ACC0_HIGH || i_araddr == OFF_ACC1_HIGH) begin
      rd_val = move_value(acc_q[i_araddr[3]], 1'b1,
                          st0_q[ST0_CLAMP_DIS]);
      rd_limit = rd_fire && !st0_q[ST0_CLAMP_DIS] &&
                 overflowed(acc_q[i_araddr[3]]);
    end else if (i_araddr == OFF_ACC0_LOW || i_araddr == OFF_ACC1_LOW) begin
      rd_val = move_value(acc_q[i_araddr[3]], 1'b0,
                          st0_q[ST0_CLAMP_DIS]);
      rd_limit = rd_fire && !st0_q[ST0_CLAMP_DIS] &&
                 overflowed(acc_q[i_araddr[3]]);
    end else if (i_araddr == OFF_SHIFT_CNT) begin
      rd_val = shift_cnt_q;
    end else if (i_araddr == OFF_STATUS0) begin
      rd_val = {12'h000, st0_q};
    end else if (i_araddr == OFF_STATUS2) begin
      rd_val = {15'h0000, st2_kind_q};
    end else if (i_araddr == OFF_ACC0_EXT) begin
      rd_val = {12'h000, acc_q[0][35:32]};
    end else if (i_araddr == OFF_ACC1_EXT) begin
      rd_val = {12'h000, acc_q[1][35:32]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      o_rvalid <= 1'b1;
      o_rdata  <= {16'h0000, rd_val};
      o_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_arready <= 1'b0;
    end else begin
      o_arready <= !o_arready && !o_rvalid && !rd_fire && i_arvalid;
    end
  end

  // ----------------------------------------------------------------
  // Datapath outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_to_primary  <= 36'h0;
      o_operand     <= 36'h0;
      o_shift_count <= 16'h0000;
    end else begin
      o_to_primary  <= (dp_op_t'(i_op) == OP_SWAP) ? acc_q[i_op_sel]
                                                   : o_to_primary;
      o_operand     <= acc_q[i_op_sel];
      o_shift_count <= shift_cnt_q;
    end
  end

endmodule

`default_nettype wire

// >>> sec_acc_slice_monitor.sv
// Purpose: Port checker for the secondary accumulator slice
// Assumes: One clock, synchronous active high reset
// Notes:   Bound to every instance of the slice
`timescale 1ns/1ps
`default_nettype none
module sec_acc_slice_monitor
  import sec_acc_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [7:0]  i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [2:0]  i_op,
  input wire logic        i_op_sel,
  input wire logic [35:0] i_primary_acc,
  input wire logic [35:0] o_operand,
  input wire logic [15:0] o_shift_count
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_swap_load: assert property (
    (i_op == OP_SWAP) ##1 (i_op == OP_NONE && i_op_sel == $past(i_op_sel))
    |=> o_operand == $past(i_primary_acc, 2)) else $error("Swap load wrong");
  a_exp_count: assert property ((i_op == OP_EXP) |=> ##1
    (o_shift_count[15:5] == 11'h000 || o_shift_count[15:5] == 11'h7ff))
    else $error("Exponent not sign extended");
  a_read_pad: assert property (
    o_rvalid |-> o_rdata[31:16] == 16'h0000) else $error("Upper bits set");
  a_read_answer: assert property (
    (i_arvalid && o_arready) |=> o_rvalid) else $error("Read not answered");
  a_unmapped_err: assert property (
    (i_arvalid && o_arready && i_araddr > OFF_ACC1_EXT)
    |=> o_rresp == RESP_SLVERR) else $error("Unmapped read not refused");
  a_bresp_hold: assert property (
    (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
    else $error("Write response dropped");
  a_rdata_hold: assert property (
    (o_rvalid && !i_rready) |=> o_rvalid && $stable(o_rdata))
    else $error("Read data dropped");
  a_write_answer: assert property (
    (i_awvalid && o_awready && i_wvalid && o_wready) |-> ##[1:4] o_bvalid)
    else $error("Write not answered");
  a_acc_hold: assert property (
    (i_op == OP_NONE && !i_awvalid && !i_wvalid && !o_bvalid &&
     $stable(i_op_sel)) [*4] |=> $stable(o_operand))
    else $error("Accumulator changed while idle");
  c_swap: cover property (i_op == OP_SWAP);
  c_clamp: cover property (i_op == OP_CLAMP);
  c_sat: cover property (o_rvalid && o_rdata[15:0] == SAT_HIGH_POS);
endmodule
bind sec_acc_slice sec_acc_slice_monitor sec_acc_slice_monitor_inst (
  .i_clock, .i_sys_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
  .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_op, .i_op_sel,
  .i_primary_acc, .o_operand, .o_shift_count);
`default_nettype wire

// >>> core_ctrl_model.sv
// Purpose: Instruction control model driving datapath operations
// Assumes: One-cycle op strobes at rising edges
// Notes:   Operands idle at inverted values between ops
`timescale 1ns/1ps
`default_nettype none
module core_ctrl_model
  import sec_acc_pkg::*;
(
  input  wire logic        i_clock,
  output var  logic [2:0]  o_op,
  output var  logic        o_op_sel,
  output var  logic        o_op_src,
  output var  logic [35:0] o_primary_acc,
  output var  logic [35:0] o_shift_src,
  output var  logic        o_shift_use_count,
  output var  logic [6:0]  o_shift_imm,
  output var  logic        o_alu_flag_we,
  output var  logic [3:0]  o_alu_flags
);
  initial begin
    o_op = OP_NONE;
    {o_op_sel, o_op_src, o_shift_use_count, o_alu_flag_we} = 4'h0;
    {o_primary_acc, o_shift_src} = 72'h0;
    o_shift_imm = 7'h00;
    o_alu_flags = 4'h0;
  end
  task automatic issue(input logic [2:0] op, input logic sel, src, uc,
                       input logic [6:0] imm, input logic [35:0] prim, sh);
    @(posedge i_clock);
    o_op <= op;
    o_op_sel <= sel;
    o_op_src <= src;
    o_shift_use_count <= uc;
    o_shift_imm <= imm;
    o_primary_acc <= prim;
    o_shift_src <= sh;
    @(posedge i_clock);
    o_op <= OP_NONE;
    o_primary_acc <= ~prim;
    o_shift_src <= ~sh;
    repeat (2) @(posedge i_clock);
  endtask
  task automatic flag(input logic [3:0] f);
    @(posedge i_clock);
    o_alu_flag_we <= 1'b1;
    o_alu_flags <= f;
    @(posedge i_clock);
    o_alu_flag_we <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> secondary_accumulator_saturation_tb.sv
// Purpose: Self-checking bench for the secondary accumulator slice
// Assumes: AXI4-Lite master tasks, 250 MHz clock
// Notes:   Wait loops are bounded by the watchdog
`timescale 1ns/1ps
`default_nettype none
module secondary_accumulator_saturation_tb
  import sec_acc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, sel, src, uc, we;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  op;
  logic [35:0] prim, shsrc, to_prim, operand;
  logic [6:0]  imm;
  logic [3:0]  flags;
  logic [15:0] shcnt;
  int          fails = 0;
  int          check_count = 0;
  always #2 clk = ~clk;
  sec_acc_slice sec_acc_slice_inst (.i_clock(clk), .i_sys_rst(rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'h3), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_op(op), .i_op_sel(sel), .i_op_src(src), .i_primary_acc(prim),
    .i_shift_src(shsrc), .i_shift_use_count(uc), .i_shift_imm(imm),
    .i_alu_flag_we(we), .i_alu_flags(flags), .o_to_primary(to_prim),
    .o_operand(operand), .o_shift_count(shcnt));
  core_ctrl_model core_ctrl_model_inst (.i_clock(clk), .o_op(op),
    .o_op_sel(sel), .o_op_src(src), .o_primary_acc(prim),
    .o_shift_src(shsrc), .o_shift_use_count(uc), .o_shift_imm(imm),
    .o_alu_flag_we(we), .o_alu_flags(flags));
  task automatic check(input logic [35:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    {awvalid, wvalid, bready} <= 3'h7;
    fork
      begin do @(negedge clk); while (awready !== 1'b1);
        @(posedge clk); awvalid <= 1'b0; end
      begin do @(negedge clk); while (wready !== 1'b1);
        @(posedge clk); wvalid <= 1'b0; end
    join
    do @(negedge clk); while (bvalid !== 1'b1);
    check(36'(bresp), 36'(er), "bresp");
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, m,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    check(36'(rdata[15:0] & m), 36'(e), "rdata");
    check(36'(rresp), 36'(er), "rresp");
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic go(input logic [2:0] o, input logic s, c, u,
                    input logic [6:0] n, input logic [35:0] p, h);
    core_ctrl_model_inst.issue(o, s, c, u, n, p, h);
  endtask
  task automatic t_halves;
    wr(OFF_STATUS0, 16'h0001, RESP_OKAY);
    wr(OFF_ACC0_HIGH, 16'h8001, RESP_OKAY);
    rd(OFF_ACC0_HIGH, 16'h8001, 16'hffff, RESP_OKAY);
    rd(OFF_ACC0_LOW, 16'h0000, 16'hffff, RESP_OKAY);
    rd(OFF_ACC0_EXT, 16'h000f, 16'h000f, RESP_OKAY);
    wr(OFF_ACC0_LOW, 16'h1234, RESP_OKAY);
    rd(OFF_ACC0_HIGH, 16'h0000, 16'hffff, RESP_OKAY);
    wr(OFF_ACC0_EXT, 16'h0003, RESP_SLVERR);
    rd(OFF_ACC0_EXT, 16'h0000, 16'h000f, RESP_OKAY);
    rd(8'h24, 16'h0000, 16'hffff, RESP_SLVERR);
    wr(OFF_SHIFT_CNT, 16'hbeef, RESP_OKAY);
    rd(OFF_SHIFT_CNT, 16'hbeef, 16'hffff, RESP_OKAY);
    check(36'(shcnt), 36'hbeef, "count out");
    $display("halves test done");
  endtask
  task automatic t_sat;
    wr(OFF_STATUS0, 16'h0000, RESP_OKAY);
    go(OP_SWAP, 1, 0, 0, 7'h00, 36'h080000000, 36'h0);
    check(to_prim, 36'h0, "swap out");
    rd(OFF_ACC1_HIGH, SAT_HIGH_POS, 16'hffff, RESP_OKAY);
    rd(OFF_ACC1_LOW, SAT_LOW_POS, 16'hffff, RESP_OKAY);
    rd(OFF_STATUS0, 16'h0008, 16'h0008, RESP_OKAY);
    wr(OFF_STATUS0, 16'h0001, RESP_OKAY);
    rd(OFF_ACC1_HIGH, 16'h8000, 16'hffff, RESP_OKAY);
    go(OP_SWAP, 1, 0, 0, 7'h00, 36'he00000000, 36'h0);
    check(to_prim, 36'h080000000, "kept value");
    wr(OFF_STATUS0, 16'h0000, RESP_OKAY);
    rd(OFF_ACC1_HIGH, SAT_HIGH_NEG, 16'hffff, RESP_OKAY);
    rd(OFF_ACC1_LOW, SAT_LOW_NEG, 16'hffff, RESP_OKAY);
    wr(OFF_STATUS0, 16'h0001, RESP_OKAY);
    go(OP_CLAMP, 1, 0, 0, 7'h00, 36'h0, 36'h0);
    rd(OFF_ACC1_EXT, 16'h000f, 16'h000f, RESP_OKAY);
    $display("saturation test done");
  endtask
  task automatic t_norm;
    go(OP_SWAP, 0, 0, 0, 7'h00, 36'h000000005, 36'h0);
    go(OP_EXP, 0, 0, 0, 7'h00, 36'h0, 36'h0);
    check(36'(shcnt), 36'h001c, "exponent");
    go(OP_SHIFT, 0, 1, 1, 7'h00, 36'h0, 36'h0);
    rd(OFF_ACC0_HIGH, 16'h5000, 16'hffff, RESP_OKAY);
    $display("normalize test done");
  endtask
  task automatic t_shift;
    wr(OFF_STATUS0, 16'h0000, RESP_OKAY);
    wr(OFF_STATUS2, 16'h0000, RESP_OKAY);
    go(OP_SHIFT, 0, 0, 0, 7'h7c, 36'h0, 36'hf00000000);
    rd(OFF_ACC0_EXT, 16'h000f, 16'h000f, RESP_OKAY);
    wr(OFF_STATUS2, 16'h0001, RESP_OKAY);
    go(OP_SHIFT, 0, 0, 0, 7'h7c, 36'h0, 36'hf00000000);
    rd(OFF_ACC0_EXT, 16'h0000, 16'h000f, RESP_OKAY);
    go(OP_SHIFT, 0, 0, 0, 7'h01, 36'h0, 36'h040000000);
    rd(OFF_STATUS0, 16'h0002, 16'h0002, RESP_OKAY);
    wr(OFF_STATUS0, 16'h0000, RESP_OKAY);
    go(OP_SHIFT, 0, 0, 0, 7'h01, 36'h0, 36'h400000000);
    rd(OFF_STATUS0, 16'h000c, 16'h000c, RESP_OKAY);
    wr(OFF_STATUS0, 16'h0000, RESP_OKAY);
    core_ctrl_model_inst.flag(4'h4);
    rd(OFF_STATUS0, 16'h0004, 16'h0004, RESP_OKAY);
    $display("shift test done");
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_halves;
    t_sat;
    t_norm;
    t_shift;
    finish_test;
  end
  initial begin
    #100000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end
endmodule
`default_nettype wire
